// ### shared/radio_modem_map.vh
// register map, field layout and reset values of the modem configuration bank
`ifndef RADIO_MODEM_MAP_VH
`define RADIO_MODEM_MAP_VH
`define ADDR_MODEM_CONFIG_HIGH 16'hdf0f
`define ADDR_MODEM_CONFIG_LOW 16'hdf10
`define ADDR_FREQ_DEVIATION 16'hdf11
`define FEC_BIT 7
`define PREAMBLE_HI 6
`define PREAMBLE_LO 4
`define STEP_EXP_HI 1
`define STEP_EXP_LO 0
`define DEV_EXP_HI 6
`define DEV_EXP_LO 4
`define DEV_MANT_HI 2
`define DEV_MANT_LO 0
`define HIGH_MASK 8'hf3
`define DEV_MASK 8'h77
`define HIGH_RESET 8'h22
`define LOW_RESET 8'hf8
`define DEV_RESET 8'h47
`define STEP_MANT_OFFSET 10'h100
`define DEV_MANT_OFFSET 4'h8
`define LOW_MASK 8'hff
`define FEC_RESET 1'b0
`define PREAMBLE_RESET_BYTES 5'h04
`define STEP_EXP_RESET 2'h2
`define DEV_EXP_RESET 3'h4
`define DEV_MANT_RESET 3'h7
`define PRE_BYTES_0 5'h02
`define PRE_BYTES_1 5'h03
`define PRE_BYTES_2 5'h04
`define PRE_BYTES_3 5'h06
`define PRE_BYTES_4 5'h08
`define PRE_BYTES_5 5'h0c
`define PRE_BYTES_6 5'h10
`define PRE_BYTES_7 5'h18
`endif

// ### rtl/radio_modem_config_regs.v
// modem configuration register bank with derived framing and synthesis values
`timescale 1ns/1ps
`include "radio_modem_map.vh"
module radio_modem_config_regs #(
  parameter CHANNEL_INDEX_W = 8,
  parameter BASE_W = 24
) (
  input wire mclk,
  input wire rst_b,
  input wire [15:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  input wire [CHANNEL_INDEX_W-1:0] channelIndex,
  input wire [BASE_W-1:0] baseFrequency,
  output reg errorCorrectionEnable,
  output reg [4:0] preambleBytes,
  output reg [1:0] channelStepExponent,
  output reg [7:0] channelStepMantissa,
  output reg [11:0] channelStep,
  output reg [BASE_W+CHANNEL_INDEX_W+4:0] operatingFrequency,
  output reg [2:0] deviationExponent,
  output reg [2:0] deviationMantissa,
  output reg [10:0] frequencyDeviation
);

  // widths of the derived quantities
  localparam STEP_W = 12;
  localparam DEV_W = 11;
  localparam FREQ_W = BASE_W + CHANNEL_INDEX_W + 5;
  localparam PROD_W = STEP_W + CHANNEL_INDEX_W;
  localparam PAD_W = FREQ_W - PROD_W;

  // stored register images
  reg [7:0] highQ;
  reg [7:0] lowQ;
  reg [7:0] devQ;

  // next values of the stored images, built bit by bit
  wire [7:0] highD;
  wire [7:0] lowD;
  wire [7:0] devD;

  // writable-bit masks per register
  wire [7:0] highMask;
  wire [7:0] lowMask;
  wire [7:0] devMask;

  // address decode and qualified write strobes
  wire hitHigh;
  wire hitLow;
  wire hitDev;
  wire writeHigh;
  wire writeLow;
  wire writeDev;

  // read data for the next cycle
  reg [7:0] readDataD;

  // fields pulled out of the stored images
  wire fecField;
  wire [2:0] preambleCode;
  wire [1:0] stepExpField;
  wire [7:0] stepMantField;
  wire [2:0] devExpField;
  wire [2:0] devMantField;

  // intermediate arithmetic
  reg [9:0] stepMantFull;
  reg [STEP_W-1:0] stepBase;
  reg [3:0] devMantFull;
  reg [DEV_W-1:0] devBase;
  reg [PROD_W-1:0] stepProduct;
  reg [FREQ_W-1:0] baseScaled;
  reg [FREQ_W-1:0] productExt;

  // next values of the outputs toward the radio core
  reg [4:0] preambleBytesD;
  reg [STEP_W-1:0] channelStepD;
  reg [DEV_W-1:0] frequencyDeviationD;
  reg [FREQ_W-1:0] operatingFrequencyD;

  // loop variable of the per-bit write logic
  genvar bitIdx;

  // masks from the map; cleared bits are not implemented
  // a mask bit of zero both blocks writes and forces zero readback
  assign highMask = `HIGH_MASK;
  assign lowMask = `LOW_MASK;
  assign devMask = `DEV_MASK;

  // one decoder per register, exact address match only
  // partial decoding would alias neighbouring radio registers
  assign hitHigh = (regAddr == `ADDR_MODEM_CONFIG_HIGH);
  assign hitLow = (regAddr == `ADDR_MODEM_CONFIG_LOW);
  assign hitDev = (regAddr == `ADDR_FREQ_DEVIATION);

  // writes to unknown addresses fall through unnoticed
  assign writeHigh = regWrite & hitHigh;
  assign writeLow = regWrite & hitLow;
  assign writeDev = regWrite & hitDev;

  // per-bit next values; masked bits never take a one
  // neighbouring fields keep their value, only the strobe matters
  generate
    for (bitIdx = 0; bitIdx < 8; bitIdx = bitIdx + 1) begin : g_bit
      assign highD[bitIdx] = writeHigh ? (regWdata[bitIdx] & highMask[bitIdx])
        : highQ[bitIdx];
      assign lowD[bitIdx] = writeLow ? (regWdata[bitIdx] & lowMask[bitIdx])
        : lowQ[bitIdx];
      assign devD[bitIdx] = writeDev ? (regWdata[bitIdx] & devMask[bitIdx])
        : devQ[bitIdx];
    end
  endgenerate

  // modem_config_high image: error correction, preamble, step exponent
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      highQ <= `HIGH_RESET;
    end else begin
      highQ <= highD;
    end
  end

  // modem_config_low image: step mantissa
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lowQ <= `LOW_RESET;
    end else begin
      lowQ <= lowD;
    end
  end

  // frequency_deviation_setting image: deviation exponent and mantissa
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      devQ <= `DEV_RESET;
    end else begin
      devQ <= devD;
    end
  end

  // read data mux; unmapped addresses and idle cycles give zero
  // zero when idle lets a wired-or bus merge several banks
  always @* begin
    readDataD = 8'h00;
    if (regRead) begin
      if (hitHigh) begin
        readDataD = highQ;
      end else if (hitLow) begin
        readDataD = lowQ;
      end else if (hitDev) begin
        readDataD = devQ;
      end else begin
        readDataD = 8'h00;
      end
    end
  end

  // read data stand for exactly one cycle after the strobe
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= readDataD;
    end
  end

  // field extraction
  assign fecField = highQ[`FEC_BIT];
  assign preambleCode = highQ[`PREAMBLE_HI:`PREAMBLE_LO];
  assign stepExpField = highQ[`STEP_EXP_HI:`STEP_EXP_LO];
  assign stepMantField = lowQ;
  assign devExpField = devQ[`DEV_EXP_HI:`DEV_EXP_LO];
  assign devMantField = devQ[`DEV_MANT_HI:`DEV_MANT_LO];

  // preamble code to minimum byte count
  // counts grow roughly by half steps, so no closed form is used
  always @* begin
    case (preambleCode)
      3'h0: preambleBytesD = `PRE_BYTES_0;
      3'h1: preambleBytesD = `PRE_BYTES_1;
      3'h2: preambleBytesD = `PRE_BYTES_2;
      3'h3: preambleBytesD = `PRE_BYTES_3;
      3'h4: preambleBytesD = `PRE_BYTES_4;
      3'h5: preambleBytesD = `PRE_BYTES_5;
      3'h6: preambleBytesD = `PRE_BYTES_6;
      3'h7: preambleBytesD = `PRE_BYTES_7;
      default: preambleBytesD = `PREAMBLE_RESET_BYTES;
    endcase
  end

  // channel step in units of fref/2^18; the hidden leading one is 256
  // largest value is 511 shifted by 3, which still fits 12 bits
  always @* begin
    stepMantFull = `STEP_MANT_OFFSET + {2'h0, stepMantField};
    stepBase = {2'h0, stepMantFull};
    channelStepD = stepBase << stepExpField;
  end

  // deviation in units of fref/2^17; the hidden leading one is 8
  // largest value is 15 shifted by 7, which still fits 11 bits
  always @* begin
    devMantFull = `DEV_MANT_OFFSET + {1'b0, devMantField};
    devBase = {7'h00, devMantFull};
    frequencyDeviationD = devBase << devExpField;
  end

  // product kept at full width so no carry is lost
  // the base is taken one channel-index width above the step units
  always @* begin
    stepProduct = {{CHANNEL_INDEX_W{1'b0}}, channelStep} * {{STEP_W{1'b0}}, channelIndex};
    baseScaled = {5'h00, baseFrequency, {CHANNEL_INDEX_W{1'b0}}};
    productExt = {{PAD_W{1'b0}}, stepProduct};
    operatingFrequencyD = baseScaled + productExt;
  end

  // error correction enable toward the framer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      errorCorrectionEnable <= `FEC_RESET;
    end else begin
      errorCorrectionEnable <= fecField;
    end
  end

  // minimum preamble byte count toward the framer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      preambleBytes <= `PREAMBLE_RESET_BYTES;
    end else begin
      preambleBytes <= preambleBytesD;
    end
  end

  // channel step exponent copy
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      channelStepExponent <= `STEP_EXP_RESET;
    end else begin
      channelStepExponent <= stepExpField;
    end
  end

  // channel step mantissa copy
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      channelStepMantissa <= `LOW_RESET;
    end else begin
      channelStepMantissa <= stepMantField;
    end
  end

  // channel step; cleared in reset, valid one edge after release
  // the synthesiser must not use it during the first cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      channelStep <= {STEP_W{1'b0}};
    end else begin
      channelStep <= channelStepD;
    end
  end

  // operating frequency; lags the step by one edge
  // built from the registered step to keep the multiplier path short
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      operatingFrequency <= {FREQ_W{1'b0}};
    end else begin
      operatingFrequency <= operatingFrequencyD;
    end
  end

  // deviation exponent copy
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      deviationExponent <= `DEV_EXP_RESET;
    end else begin
      deviationExponent <= devExpField;
    end
  end

  // deviation mantissa copy
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      deviationMantissa <= `DEV_MANT_RESET;
    end else begin
      deviationMantissa <= devMantField;
    end
  end

  // nominal deviation; cleared in reset like the channel step
  // valid from the first edge after release
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frequencyDeviation <= {DEV_W{1'b0}};
    end else begin
      frequencyDeviation <= frequencyDeviationD;
    end
  end

endmodule

// ### dv/radio_modem_config_assertions.sv
// assertions on the modem configuration register bank
`timescale 1ns/1ps
module radio_modem_config_checker (
  input wire mclk,
  input wire rst_b,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regAddr,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  input wire errorCorrectionEnable,
  input wire [4:0] preambleBytes,
  input wire [1:0] channelStepExponent,
  input wire [7:0] channelStepMantissa,
  input wire [11:0] channelStep,
  input wire [2:0] deviationExponent,
  input wire [2:0] deviationMantissa,
  input wire [10:0] frequencyDeviation
);
  reg [7:0] w1;
  reg [7:0] w2;
  wire hiW;
  wire dvW;
  assign hiW = regWrite && regAddr == 16'hdf0f;
  assign dvW = regWrite && regAddr == 16'hdf11;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // write data delayed to line up with the derived outputs
  always @(posedge mclk) {w2, w1} <= {w1, regWdata};
  chk_fec_bit: assert property (hiW |-> ##2 errorCorrectionEnable == w2[7])
    else $error("fec");
  chk_preamble_map: assert property (hiW |-> ##2
    preambleBytes == ((w2[4] ? 5'd3 : 5'd2) << w2[6:5])) else $error("preamble");
  chk_step_exp: assert property (hiW |-> ##2 channelStepExponent == w2[1:0])
    else $error("exponent");
  chk_step_mant: assert property (regWrite && regAddr == 16'hdf10 |-> ##2
    channelStepMantissa == w2) else $error("mantissa");
  chk_step_calc: assert property ($past(rst_b) |->
    channelStep == ((12'h100 + channelStepMantissa) << channelStepExponent)) else $error("step");
  chk_dev_calc: assert property (dvW |-> ##2
    frequencyDeviation == ((11'h8 + w2[2:0]) << w2[6:4])) else $error("deviation");
  chk_unused_zero: assert property (regRead && regAddr == 16'hdf0f |=>
    regRdata[3:2] == 2'b00) else $error("unused");
  chk_dev_fields: assert property (dvW |-> ##2
    deviationExponent == w2[6:4] && deviationMantissa == w2[2:0]) else $error("dev fields");
  chk_rdata_idle: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not idle");
  cover property (hiW && regWdata[7]);
  cover property (dvW);
  cover property (regRead && regAddr == 16'hdf12);
endmodule
bind radio_modem_config_regs radio_modem_config_checker i_chk (
  .mclk(mclk),
  .rst_b(rst_b),
  .regWrite(regWrite),
  .regRead(regRead),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regRdata(regRdata),
  .errorCorrectionEnable(errorCorrectionEnable),
  .preambleBytes(preambleBytes),
  .channelStepExponent(channelStepExponent),
  .channelStepMantissa(channelStepMantissa),
  .channelStep(channelStep),
  .deviationExponent(deviationExponent),
  .deviationMantissa(deviationMantissa),
  .frequencyDeviation(frequencyDeviation)
);

// ### dv/tb_top.sv
// register traffic with readback and frequency checks
`timescale 1ns/1ps
module tb_top;
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg [15:0] regAddr = 16'h0000;
  reg [7:0] regWdata = 8'h00;
  reg [7:0] channelIndex = 8'h00;
  reg [23:0] baseFrequency = 24'h000000;
  reg [7:0] d;
  reg [7:0] q;
  reg [7:0] sh [0:3];
  wire [7:0] regRdata;
  wire [36:0] operatingFrequency;
  integer errors = 0;
  integer samples_checked = 0;
  integer i;
  integer a;
  radio_modem_config_regs i_dut (
    .mclk(mclk),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .channelIndex(channelIndex),
    .baseFrequency(baseFrequency),
    .errorCorrectionEnable(),
    .preambleBytes(),
    .channelStepExponent(),
    .channelStepMantissa(),
    .channelStep(),
    .operatingFrequency(operatingFrequency),
    .deviationExponent(),
    .deviationMantissa(),
    .frequencyDeviation()
  );
  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  // writable bits of each register index; index 3 is unmapped
  function [7:0] write_mask(input integer idx);
    write_mask = idx == 0 ? 8'hf3 : idx == 1 ? 8'hff : idx == 2 ? 8'h77 : 8'h00;
  endfunction
  // base scaled by the channel-index width plus step times index
  function [63:0] exp_freq(input [7:0] mant, input [1:0] ex, input [23:0] base,
    input [7:0] idx);
    exp_freq = ({40'h0, base} << 8) + ((64'h100 + mant) << ex) * idx;
  endfunction
  // compare and count
  task chk(input [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one access at address index a; read data taken in the cycle after the strobe
  task bus(input w);
    begin
      @(posedge mclk);
      regWrite <= w;
      regRead <= !w;
      regAddr <= 16'hdf0f + a[15:0];
      regWdata <= d;
      {channelIndex, baseFrequency} <= $urandom;
      @(posedge mclk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      #1 q = regRdata;
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // reset values and unmapped read, every preamble code, then random traffic
  initial begin
    a = $urandom(32'h42efb549);
    sh[0] = 8'h22;
    sh[1] = 8'hf8;
    sh[2] = 8'h47;
    sh[3] = 8'h00;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    for (i = 0; i < 44; i++) begin
      a = i < 4 ? i : i < 12 ? 0 : $urandom % 3;
      d = i < 12 ? {i[0], i[2:0], 4'hf} : $urandom;
      // error correction set freely: bit 7 follows i[0] in the directed writes
      if (i > 3) begin
        bus(1'b1);
        sh[a] = d & write_mask(a);
      end
      bus(1'b0);
      chk(q, sh[a]);
      chk(operatingFrequency, exp_freq(sh[1], sh[0][1:0], baseFrequency, channelIndex));
    end
    report_and_stop;
  end
endmodule
